// file: include/dcw_pkg.sv
package dcw_pkg;
  // axi4-lite responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // register byte addresses
  localparam logic [7:0]  ADDR_CFG_SOURCE  = 8'h00;
  localparam logic [7:0]  ADDR_STATUS      = 8'h04;
  localparam logic [7:0]  ADDR_OSC_CTRL    = 8'h08;
  localparam logic [7:0]  ADDR_PWM_KEY     = 8'h0c;
  localparam logic [7:0]  ADDR_PWM_REG     = 8'h10;
  // config word field positions
  localparam int          POS_CODE_PROT    = 0;
  localparam int          POS_WRITE_PROT   = 1;
  localparam int          POS_TWO_SPEED    = 2;
  localparam int          POS_PWM_LOCK     = 3;
  localparam int          POS_OSC_SEL      = 4;
  localparam int          CFG_W            = 7;
  localparam logic [6:0]  CFG_RESET        = 7'h7f;
  // oscillator select codes
  localparam logic [2:0]  OSC_FAST_DIV_N   = 3'h7;
  localparam logic [2:0]  OSC_FAST_DIV_16  = 3'h6;
  localparam logic [2:0]  OSC_LP_RC        = 3'h5;
  localparam logic [2:0]  OSC_RESERVED     = 3'h4;
  localparam logic [2:0]  OSC_PRI_PLL      = 3'h3;
  localparam logic [2:0]  OSC_PRI          = 3'h2;
  localparam logic [2:0]  OSC_FAST_N_PLL   = 3'h1;
  localparam logic [2:0]  OSC_FAST_RC      = 3'h0;
  // pwm unlock key pair
  localparam logic [31:0] PWM_KEY_FIRST    = 32'h0000abcd;
  localparam logic [31:0] PWM_KEY_SECOND   = 32'h00004321;
  localparam logic [1:0]  KEY_IDLE         = 2'h0;
  localparam logic [1:0]  KEY_HALF         = 2'h1;
  localparam logic [1:0]  KEY_OPEN         = 2'h2;

  typedef struct packed {
    logic       general_code_protect;
    logic       general_write_protect;
    logic       two_speed_startup_enable;
    logic       pwm_write_lock_enable;
    logic [2:0] initial_oscillator_select;
  } dcw_cfg_t;

  typedef struct packed {
    logic       use_fast_rc;
    logic       use_div_n;
    logic       use_div_16;
    logic       use_lp_rc;
    logic       use_primary;
    logic       use_pll;
    logic       reserved_code;
  } dcw_osc_t;
endpackage : dcw_pkg

// file: hdl/dcw_osc_decode.sv
`timescale 1ns/1ps
module dcw_osc_decode (
  input  wire logic [2:0]      sel,
  output dcw_pkg::dcw_osc_t    osc
);
  import dcw_pkg::*;

  always_comb begin
    osc = '0;
    case (sel)
      OSC_FAST_DIV_N: begin  // RULE5
        osc.use_fast_rc = 1'b1;
        osc.use_div_n   = 1'b1;
      end
      OSC_FAST_DIV_16: begin  // RULE5
        osc.use_fast_rc = 1'b1;
        osc.use_div_16  = 1'b1;
      end
      OSC_LP_RC: begin  // RULE5
        osc.use_lp_rc = 1'b1;
      end
      OSC_PRI_PLL: begin  // RULE6
        osc.use_primary = 1'b1;
        osc.use_pll     = 1'b1;
      end
      OSC_PRI: begin  // RULE6
        osc.use_primary = 1'b1;
      end
      OSC_FAST_N_PLL: begin  // RULE5
        osc.use_fast_rc = 1'b1;
        osc.use_div_n   = 1'b1;
        osc.use_pll     = 1'b1;
      end
      OSC_FAST_RC: begin  // RULE5
        osc.use_fast_rc = 1'b1;
      end
      default: begin
        // reserved code: flag it and fall back to plain fast rc
        osc.use_fast_rc   = 1'b1;
        osc.reserved_code = 1'b1;  // RULE7
      end
    endcase
  end
endmodule : dcw_osc_decode

// file: hdl/dcw_config_decode.sv
`timescale 1ns/1ps
// Contract
// RULE1 - code-protect 0 protects all program memory from readout; 1 leaves it open
// RULE2 - write-protect 0 blocks user program memory writes; 1 permits them
// RULE3 - two-speed 1 starts on fast rc, then switches once selected source ready
// RULE4 - pwm lock 1 rejects pwm register writes until key sequence done
// RULE5 - oscillator codes 111,110,101,001,000 select the internal rc variants
// RULE6 - code 011 selects primary with pll, 010 primary without pll
// RULE7 - programmer must never use reserved oscillator code 100
// RULE8 - settings sampled once at start-up, held until next reset
module dcw_config_decode (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [6:0]          cfg_word,
  input  wire logic                cfg_valid,
  input  wire logic                osc_source_ready,
  output dcw_pkg::dcw_osc_t        osc_select,
  output logic                     running_on_fast_rc,
  output logic                     core_run,
  output logic                     readout_blocked,
  output logic                     prog_write_blocked,
  output logic [15:0]              pwm_reg_value,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import dcw_pkg::*;

  typedef enum logic [2:0] {
    ST_LOAD   = 3'b001,
    ST_FAST   = 3'b010,
    ST_RUN    = 3'b100
  } dcw_state_t;

  dcw_state_t        state_ff;
  dcw_cfg_t          cfg_ff;
  logic              loaded_ff;
  dcw_osc_t          osc_dec;
  logic              fast_ff;
  logic              rd_prot_ff;
  logic              wr_prot_ff;
  logic [1:0]        key_ff;
  logic [15:0]       pwm_ff;
  logic [31:0]       aw_addr_ff;
  logic              aw_have_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              w_have_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              wr_fire;
  logic [7:0]        wr_addr;
  logic [1:0]        nxt_key;

  // sampled once; no path lets software or the pins change it later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff    <= CFG_RESET;
      loaded_ff <= 1'b0;
    end else if (!loaded_ff && cfg_valid) begin
      cfg_ff.general_code_protect      <= cfg_word[POS_CODE_PROT];  // RULE8
      cfg_ff.general_write_protect     <= cfg_word[POS_WRITE_PROT];
      cfg_ff.two_speed_startup_enable  <= cfg_word[POS_TWO_SPEED];
      cfg_ff.pwm_write_lock_enable     <= cfg_word[POS_PWM_LOCK];
      cfg_ff.initial_oscillator_select <= cfg_word[POS_OSC_SEL +: 3];
      loaded_ff                        <= 1'b1;  // RULE8
    end
  end

  dcw_osc_decode u_osc (
    .sel (cfg_ff.initial_oscillator_select),
    .osc (osc_dec)
  );

  // start-up sequence: core held until config loaded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_LOAD;
      fast_ff  <= 1'b1;
    end else begin
      case (state_ff)
        ST_LOAD: begin
          if (!loaded_ff && cfg_valid) begin
            if (cfg_word[POS_TWO_SPEED]) begin
              state_ff <= ST_FAST;  // RULE3
              fast_ff  <= 1'b1;
            end else begin
              state_ff <= ST_RUN;  // RULE3
              fast_ff  <= 1'b0;
            end
          end
        end
        ST_FAST: begin
          if (osc_source_ready) begin
            state_ff <= ST_RUN;  // RULE3
            fast_ff  <= 1'b0;
          end
        end
        ST_RUN: begin
          fast_ff <= 1'b0;
        end
        default: begin
          state_ff <= ST_LOAD;
          fast_ff  <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_prot_ff <= 1'b1;
      wr_prot_ff <= 1'b1;
    end else begin
      rd_prot_ff <= !cfg_ff.general_code_protect || !loaded_ff;  // RULE1
      wr_prot_ff <= !cfg_ff.general_write_protect || !loaded_ff;  // RULE2
    end
  end

  assign osc_select         = osc_dec;
  assign running_on_fast_rc = fast_ff;
  assign core_run           = (state_ff != ST_LOAD);
  assign readout_blocked    = rd_prot_ff;
  assign prog_write_blocked = wr_prot_ff;
  assign pwm_reg_value      = pwm_ff;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_ff <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !bvalid_ff;
  assign wr_fire       = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_addr       = aw_addr_ff[7:0];

  // key must be the very next write after the first half, else it rearms
  always_comb begin
    nxt_key = key_ff;
    if (wr_fire) begin
      if (wr_addr == ADDR_PWM_KEY) begin
        if (w_data_ff == PWM_KEY_FIRST) begin
          nxt_key = KEY_HALF;
        end else if (key_ff == KEY_HALF && w_data_ff == PWM_KEY_SECOND) begin
          nxt_key = KEY_OPEN;
        end else begin
          nxt_key = KEY_IDLE;
        end
      end else begin
        nxt_key = KEY_IDLE;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_ff <= KEY_IDLE;
    end else begin
      key_ff <= nxt_key;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_ff <= '0;
    end else if (wr_fire && wr_addr == ADDR_PWM_REG) begin
      if (!cfg_ff.pwm_write_lock_enable || key_ff == KEY_OPEN) begin  // RULE4
        if (w_strb_ff[0]) pwm_ff[7:0]  <= w_data_ff[7:0];
        if (w_strb_ff[1]) pwm_ff[15:8] <= w_data_ff[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      if (wr_addr == ADDR_PWM_KEY) begin
        bresp_ff <= RESP_OKAY;
      end else if (wr_addr == ADDR_PWM_REG) begin
        bresp_ff <= (cfg_ff.pwm_write_lock_enable && key_ff != KEY_OPEN)
                    ? RESP_SLVERR : RESP_OKAY;  // RULE4
      end else begin
        bresp_ff <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // read channel
  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      case (s_axi_araddr[7:0])
        ADDR_CFG_SOURCE: rdata_ff <= {25'h0, cfg_ff};
        ADDR_STATUS:     rdata_ff <= {24'h0, osc_dec.reserved_code, key_ff, state_ff,
                                      fast_ff, loaded_ff};
        ADDR_OSC_CTRL:   rdata_ff <= {25'h0, osc_dec};
        ADDR_PWM_KEY:    rdata_ff <= {30'h0, key_ff};
        ADDR_PWM_REG:    rdata_ff <= {16'h0, pwm_ff};
        default: begin
          rdata_ff <= '0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
endmodule : dcw_config_decode

// file: dv/dcw_config_decode_sva.sv
`timescale 1ns/1ps
module dcw_config_decode_sva
  import dcw_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [6:0]        cfg_word,
  input wire logic              cfg_valid,
  input wire dcw_pkg::dcw_osc_t osc_select,
  input wire logic              running_on_fast_rc,
  input wire logic              core_run,
  input wire logic              readout_blocked,
  input wire logic              prog_write_blocked,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  logic       ld_ff;
  logic [6:0] cw_ff;
  logic [6:0] eo;
  always_ff @(posedge aclk) begin
    if (!aresetn) ld_ff <= 1'b0;
    else if (cfg_valid) ld_ff <= 1'b1;
  end
  // shadow of the word taken at load
  always_ff @(posedge aclk) begin
    if (aresetn && cfg_valid && !ld_ff) cw_ff <= cfg_word;
  end
  always_comb begin
    case (cw_ff[6:4])
      3'h7: eo = 7'h60;
      3'h6: eo = 7'h50;
      3'h5: eo = 7'h08;
      3'h4: eo = 7'h41;
      3'h3: eo = 7'h06;
      3'h2: eo = 7'h04;
      3'h1: eo = 7'h62;
      default: eo = 7'h40;
    endcase
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  load_run_a: assert property (core_run == ld_ff) else $error("core_run off load");
  code_prot_a: assert property (core_run && $past(core_run, 2) |->
    readout_blocked == !cw_ff[0]) else $error("readout block wrong");
  write_prot_a: assert property (core_run && $past(core_run, 2) |->
    prog_write_blocked == !cw_ff[1]) else $error("write block wrong");
  osc_sel_a: assert property (core_run && $past(core_run, 2) |->
    osc_select == eo) else $error("osc decode wrong");
  osc_hold_a: assert property (core_run && $past(core_run, 2) |->
    $stable(osc_select)) else $error("osc changed");
  direct_start_a: assert property (core_run && $past(core_run, 2) && !cw_ff[2] |->
    !running_on_fast_rc) else $error("fast rc without two-speed");
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
endmodule : dcw_config_decode_sva

bind dcw_config_decode dcw_config_decode_sva chk_i (.aclk, .aresetn, .cfg_word, .cfg_valid,
  .osc_select, .running_on_fast_rc, .core_run, .readout_blocked, .prog_write_blocked,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// file: dv/test_device_config_word_decode.sv
`timescale 1ns/1ps
module test_device_config_word_decode;
  import dcw_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, cfg_valid = 1'b0, osc_source_ready = 1'b0;
  logic [6:0] cfg_word = 7'h00;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  dcw_osc_t osc_select;
  logic running_on_fast_rc, core_run, readout_blocked, prog_write_blocked;
  logic [15:0] pwm_reg_value;
  int num_errors = 0, checks = 0, n;
  // {cfg word, expected decode}; code 100 never sent
  logic [13:0] rows [7] = '{14'h39e0, 14'h3050, 14'h2908, 14'h1886, 14'h1184,
                            14'h09e2, 14'h0040};
  always #2.5 aclk = ~aclk;
  dcw_config_decode uut (.aclk, .aresetn, .cfg_word, .cfg_valid, .osc_source_ready,
    .osc_select, .running_on_fast_rc, .core_run, .readout_blocked, .prog_write_blocked,
    .pwm_reg_value, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tmo;
    if (n >= 30) begin
      num_errors++;
      end_sim();
    end
  endtask : tmo
  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    cfg_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  task automatic load(input logic [6:0] c);
    @(posedge aclk);
    cfg_word <= c;
    cfg_valid <= 1'b1;
    for (n = 0; n < 30 && core_run !== 1'b1; n++) @(posedge aclk);
    tmo();
    repeat (2) @(posedge aclk);
  endtask : load
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 30; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo();
    chk(s_axi_bresp, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 30; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    tmo();
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask : rd
  initial begin
    rst();
    repeat (2) @(posedge aclk);
    chk(core_run, 1'b0);
    chk(readout_blocked, 1'b1);
    chk(prog_write_blocked, 1'b1);
    chk(running_on_fast_rc, 1'b1);
    foreach (rows[i]) begin
      rst();
      load(rows[i][13:7]);
      // a later word must not leak through
      cfg_word <= 7'h2c;
      repeat (2) @(posedge aclk);
      chk(osc_select, rows[i][6:0]);
      chk(readout_blocked, !rows[i][7]);
      chk(prog_write_blocked, !rows[i][8]);
      chk(running_on_fast_rc, 1'b0);
    end
    rst();
    load(7'h35);
    repeat (3) @(posedge aclk);
    chk(running_on_fast_rc, 1'b1);
    osc_source_ready <= 1'b1;
    for (n = 0; n < 30 && running_on_fast_rc !== 1'b0; n++) @(posedge aclk);
    tmo();
    wr(ADDR_PWM_REG, 32'h00aa, RESP_OKAY);
    chk(pwm_reg_value, 32'h00aa);
    rst();
    load(7'h0b);
    wr(ADDR_PWM_REG, 32'h1234, RESP_SLVERR);
    rd(ADDR_PWM_REG, 32'h0, RESP_OKAY);
    wr(ADDR_PWM_KEY, PWM_KEY_FIRST, RESP_OKAY);
    wr(ADDR_PWM_KEY, PWM_KEY_SECOND, RESP_OKAY);
    wr(ADDR_PWM_REG, 32'h1234, RESP_OKAY);
    rd(ADDR_PWM_REG, 32'h1234, RESP_OKAY);
    // key closes after one unlocked write
    wr(ADDR_PWM_REG, 32'h5678, RESP_SLVERR);
    rd(ADDR_PWM_REG, 32'h1234, RESP_OKAY);
    // readback is struct order: protect bits high, osc select low
    rd(ADDR_CFG_SOURCE, 32'h68, RESP_OKAY);
    rd(ADDR_OSC_CTRL, 32'h40, RESP_OKAY);
    rd(ADDR_STATUS, 32'h11, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    end_sim();
  end
endmodule : test_device_config_word_decode
